// >>> src/ups_device.sv
// Transceiver end: reset combining, supply modes and start-up handshake
module ups_device (
  // Clock and internal power-on reset
  input wire logic clk,
  input wire logic porLowN,
  // Link pins
  ups_if.dev lnk,
  // Supply and clock status
  input wire logic coreSupply1v8,
  input wire logic usbSupply3v3,
  input wire logic referenceClockIn,
  input wire logic pllLocked,
  input wire logic [1:0] uartRegulatorLevelSelIn,
  input wire logic uartLevelWrite,
  // Status
  output logic devRunning,
  output logic regAccessOnly,
  output logic standby,
  output logic syncMode,
  output logic [1:0] uartRegulatorLevelSel,
  output ups_pkg::ups_mode_t opMode
);

  // ****************************************************************
  // Reset combining
  // ****************************************************************
  logic rawRstN;
  logic [1:0] rstSync_ff;
  logic rstN;

  assign rawRstN = porLowN & lnk.hwResetLowPin; // [R1] [R8]

  // Asynchronous assert, synchronous release; pin may rise anytime
  always_ff @(posedge clk or negedge rawRstN) begin // [R20] [R8]
    if (!rawRstN) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ups_pkg::ups_dev_state_t st;
    logic dir;
    logic [1:0] uartLevel;
  } ups_dev_regs_t;

  ups_dev_regs_t cur_ff;
  ups_dev_regs_t nxt_cur;
  logic clkGo;

  // Reference clock taken as a synchronous level; start counts from it
  assign clkGo = referenceClockIn & coreSupply1v8; // [R7] [R13]

  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      ups_pkg::UPS_ST_RESET: begin
        nxt_cur.dir = 1'b1;
        if (clkGo) begin // [R7] [R13]
          nxt_cur.st = ups_pkg::UPS_ST_WAIT_LOCK;
        end
      end
      ups_pkg::UPS_ST_WAIT_LOCK: begin
        nxt_cur.dir = 1'b1; // [R9]
        if (pllLocked) begin
          nxt_cur.st = ups_pkg::UPS_ST_WAIT_STP;
        end
      end
      ups_pkg::UPS_ST_WAIT_STP: begin
        if (!pllLocked) begin
          nxt_cur.st = ups_pkg::UPS_ST_WAIT_LOCK;
        end else if (!lnk.stp) begin // [R10] [R11]
          nxt_cur.dir = 1'b0;
          nxt_cur.st = ups_pkg::UPS_ST_RUN;
        end
      end
      ups_pkg::UPS_ST_RUN: begin
        nxt_cur.dir = 1'b0;
        // Interface keeps running without bus voltage
        if (!coreSupply1v8) begin // [R16]
          nxt_cur.st = ups_pkg::UPS_ST_RESET;
          nxt_cur.dir = 1'b1;
        end
      end
      default: begin
        nxt_cur.st = ups_pkg::UPS_ST_RESET;
        nxt_cur.dir = 1'b1;
      end
    endcase
    if (uartLevelWrite && cur_ff.st == ups_pkg::UPS_ST_RUN) begin
      nxt_cur.uartLevel = uartRegulatorLevelSelIn; // [R18]
    end
    // Core supply loss reloads every default, as a fresh power-up would
    if (!coreSupply1v8) begin // [R3]
      nxt_cur.st = ups_pkg::UPS_ST_RESET;
      nxt_cur.dir = 1'b1;
      nxt_cur.uartLevel = ups_pkg::UART_LEVEL_RST;
    end
  end

  // Defaults reloaded on any reset source, including core power-up
  always_ff @(posedge clk or negedge rstN) begin // [R2] [R3]
    if (!rstN) begin
      cur_ff <= '{st: ups_pkg::UPS_ST_RESET, dir: 1'b1,
                 uartLevel: ups_pkg::UART_LEVEL_RST};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic active;
  // DIR stays up through reset only while the core supply is on; without it DIR is low and the link may drive the bus
  assign active = coreSupply1v8;

  // Without the core supply DIR is driven low and the data pins float, whatever the reset pin
  assign lnk.dir = active & cur_ff.dir; // [R9] [R15]
  assign lnk.devData = ups_pkg::BUS_IDLE; // [R9]
  assign lnk.devDataOe = active & cur_ff.dir;

  assign devRunning = active && cur_ff.st == ups_pkg::UPS_ST_RUN; // [R1]
  assign syncMode = active; // [R6]
  assign uartRegulatorLevelSel = cur_ff.uartLevel;

  always_comb begin
    if (!coreSupply1v8) begin
      opMode = usbSupply3v3 ? ups_pkg::UPS_MODE_INACTIVE
                            : ups_pkg::UPS_MODE_OFF; // [R15]
    end else if (!lnk.hwResetLowPin) begin
      opMode = ups_pkg::UPS_MODE_STANDBY; // [R15]
    end else if (!usbSupply3v3) begin
      opMode = ups_pkg::UPS_MODE_REG_ONLY; // [R14]
    end else begin
      opMode = ups_pkg::UPS_MODE_FULL;
    end
  end
  assign regAccessOnly = opMode == ups_pkg::UPS_MODE_REG_ONLY; // [R14]
  assign standby = opMode == ups_pkg::UPS_MODE_STANDBY; // [R15]

endmodule : ups_device

// >>> shared/ups_pkg.sv
// Shared constants and types for the start-up sequencer, both ends
// Notes on behaviour
// R1: Leave reset only when both resets high
// R2: Pin low one microsecond resets everything
// R3: Core supply power-up loads register defaults
// R4: Link always drives reset pin level
// R5: Link holds reset low until supply stable
// R6: Power-up default is synchronous link mode
// R7: Start needs supplies, reference clock, reset high
// R8: Reset pin release may be asynchronous
// R9: Hold DIR and idle bus until lock
// R10: After lock, check STP low first
// R11: Keep DIR high while STP stays high
// R12: Link drives idle one cycle after DIR
// R13: Start-up timed from late reference clock
// R14: No 3.3 V domain: register access only
// R15: No core supply: inactive; reset low: standby
// R16: Bus-powered interface keeps working without bus
// R17: Link enters low power when bus lost
// R18: Two-bit field sets UART regulator level
// R19: STP wakes device from low power
// R20: Combined reset: async assert, sync release
package ups_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Bus values and defaults
  // ****************************************************************
  localparam logic [7:0] BUS_IDLE = 8'h00;
  localparam logic [1:0] UART_LEVEL_RST = 2'h0;

  // Operating modes from the supply configuration
  typedef enum logic [2:0] {
    UPS_MODE_OFF = 3'h0,
    UPS_MODE_STANDBY = 3'h1,
    UPS_MODE_REG_ONLY = 3'h2,
    UPS_MODE_FULL = 3'h3,
    UPS_MODE_INACTIVE = 3'h4
  } ups_mode_t;

  // Device start-up states, Gray coded along the path
  typedef enum logic [1:0] {
    UPS_ST_RESET = 2'b00,
    UPS_ST_WAIT_LOCK = 2'b01,
    UPS_ST_WAIT_STP = 2'b11,
    UPS_ST_RUN = 2'b10
  } ups_dev_state_t;

  // Link start-up states
  typedef enum logic [1:0] {
    UPS_LS_HOLD = 2'b00,
    UPS_LS_RELEASED = 2'b01,
    UPS_LS_READY = 2'b11,
    UPS_LS_SLEEP = 2'b10
  } ups_link_state_t;

endpackage : ups_pkg

// >>> shared/ups_if.sv
// Link pins between the transceiver start-up logic and the link
interface ups_if;
  logic hwResetLowPin;
  logic dir;
  logic stp;
  logic [7:0] devData;
  logic devDataOe;
  logic [7:0] linkData;
  logic linkDataOe;

  modport dev (
    input hwResetLowPin,
    input stp,
    input linkData,
    input linkDataOe,
    output dir,
    output devData,
    output devDataOe
  );

  modport link (
    output hwResetLowPin,
    output stp,
    output linkData,
    output linkDataOe,
    input dir,
    input devData,
    input devDataOe
  );
endinterface : ups_if

// >>> src/ups_link.sv
// Link end: drives the reset pin, STP and the bus during start-up
module ups_link #(
  parameter int RESET_CYC = ups_pkg::RESET_MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link pins
  ups_if.link lnk,
  // User side
  input wire logic supplyStable,
  input wire logic linkReady,
  input wire logic holdStp,
  input wire logic resetReq,
  input wire logic busPresent,
  input wire logic busInterrupt,
  output logic phyReady,
  output logic lowPowerReq
);

  typedef struct packed {
    ups_pkg::ups_link_state_t st;
    logic [15:0] cnt;
    logic rstPin;
    logic dirSeen;
    logic stp;
  } ups_link_regs_t;

  ups_link_regs_t cur_ff;
  ups_link_regs_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.dirSeen = lnk.dir;
    case (cur_ff.st)
      ups_pkg::UPS_LS_HOLD: begin
        nxt_cur.rstPin = 1'b0;
        if (cur_ff.cnt != 16'h0000) begin
          nxt_cur.cnt = cur_ff.cnt - 16'h0001;
        end else if (supplyStable && linkReady) begin // [R5] [R2]
          nxt_cur.rstPin = 1'b1;
          nxt_cur.st = ups_pkg::UPS_LS_RELEASED;
        end
      end
      ups_pkg::UPS_LS_RELEASED: begin
        nxt_cur.stp = holdStp;
        // Bus is ours once DIR is low and our own STP has dropped
        if (!lnk.dir && !cur_ff.stp) begin
          nxt_cur.st = ups_pkg::UPS_LS_READY; // [R12]
        end
      end
      ups_pkg::UPS_LS_READY: begin
        nxt_cur.stp = 1'b0;
        if (!busPresent) begin // [R17]
          nxt_cur.st = ups_pkg::UPS_LS_SLEEP;
        end
      end
      ups_pkg::UPS_LS_SLEEP: begin
        if (busInterrupt) begin // [R19]
          nxt_cur.stp = 1'b1;
          nxt_cur.st = ups_pkg::UPS_LS_RELEASED;
        end
      end
      default: nxt_cur.st = ups_pkg::UPS_LS_HOLD;
    endcase
    if (resetReq) begin // [R2]
      nxt_cur.st = ups_pkg::UPS_LS_HOLD;
      nxt_cur.rstPin = 1'b0;
      nxt_cur.cnt = 16'(RESET_CYC);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '{st: ups_pkg::UPS_LS_HOLD, cnt: 16'(RESET_CYC),
                 rstPin: 1'b0, dirSeen: 1'b1, stp: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Reset pin is always driven, never left floating
  assign lnk.hwResetLowPin = cur_ff.rstPin; // [R4]
  assign lnk.stp = cur_ff.stp; // [R11]
  assign lnk.linkData = ups_pkg::BUS_IDLE;
  // Idle driven from the cycle after DIR falls
  assign lnk.linkDataOe = !lnk.dir && !cur_ff.dirSeen; // [R12]
  assign phyReady = cur_ff.st == ups_pkg::UPS_LS_READY;
  assign lowPowerReq = cur_ff.st == ups_pkg::UPS_LS_SLEEP; // [R17]

endmodule : ups_link

// >>> tb/ups_chk.sv
// Assertions on the link pins between the two start-up ends
module ups_chk (
  // Clock and link reset
  input wire logic clk,
  input wire logic nrst,
  // Device status
  input wire logic pllLocked,
  // Link pins
  input wire logic hwResetLowPin,
  input wire logic dir,
  input wire logic stp,
  input wire logic [7:0] devData,
  input wire logic devDataOe,
  input wire logic [7:0] linkData,
  input wire logic linkDataOe
);
  // ****************************************************************
  // Start-up handshake
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Pin-low length in cycles, saturating
  logic [15:0] lowCnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowCnt_ff <= 16'h0000;
    end else if (hwResetLowPin) begin
      lowCnt_ff <= 16'h0000;
    end else if (lowCnt_ff != 16'hFFFF) begin
      lowCnt_ff <= lowCnt_ff + 16'h0001;
    end
  end

  sequence s_pinLow;
    !hwResetLowPin [*2];
  endsequence
  // Link takes the bus one cycle after the turnaround
  sequence s_linkIdle;
    !dir ##1 linkDataOe && linkData == ups_pkg::BUS_IDLE;
  endsequence

  property p_pinLow; $fell(hwResetLowPin) |-> s_pinLow; endproperty
  a_pinLow: assert property (p_pinLow)
    else $error("reset pin pulse too short");
  property p_pinWidth;
    $rose(hwResetLowPin) |-> lowCnt_ff >= 16'(ups_pkg::RESET_MIN_CYC);
  endproperty
  a_pinWidth: assert property (p_pinWidth)
    else $error("reset pin low for less than one microsecond");
  property p_dirRst; $fell(hwResetLowPin) |=> dir; endproperty
  a_dirRst: assert property (p_dirRst)
    else $error("dir low while reset pin low");
  property p_hold; $rose(hwResetLowPin) |-> dir [*3]; endproperty
  a_hold: assert property (p_hold)
    else $error("dir dropped right after reset release");
  property p_lock; dir && !pllLocked |=> dir; endproperty
  a_lock: assert property (p_lock)
    else $error("dir dropped without lock");
  property p_stp; dir && stp |=> dir; endproperty
  a_stp: assert property (p_stp)
    else $error("dir dropped while stp high");
  property p_fall;
    $fell(dir) |-> $past(stp) == 1'b0 && $past(pllLocked);
  endproperty
  a_fall: assert property (p_fall)
    else $error("dir fell without lock and stp low");
  property p_idle;
    dir && !pllLocked |-> devDataOe && devData == ups_pkg::BUS_IDLE;
  endproperty
  a_idle: assert property (p_idle)
    else $error("device bus not idle before lock");
  property p_linkIdle; $fell(dir) |-> s_linkIdle; endproperty
  a_linkIdle: assert property (p_linkIdle)
    else $error("link did not drive idle after turnaround");
endmodule : ups_chk

// >>> tb/ulpi_phy_startup_reset_sequencer_bench.sv
// Bench joining both start-up ends through the link interface
module ulpi_phy_startup_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int k; logic [7:0] e;} ups_note_t;
  logic clk = 1'b0, nrst = 1'b0, porLowN = 1'b0, core = 1'b1, u33 = 1'b1;
  logic reference_clock_in = 1'b1, lock = 1'b1, lvlWr = 1'b0, sup = 1'b1, rdy = 1'b1;
  logic hold = 1'b1, rreq = 1'b0, bus = 1'b1, bint = 1'b0;
  logic [1:0] lvlIn = 2'h0;
  logic running, regOnly, stby, sync, phyReady, lowPower;
  logic [1:0] lvl;
  logic [31:0] v;
  ups_pkg::ups_mode_t mode;
  int errors = 0, nChecks = 0, seed = 32'h6F7971A9;
  ups_note_t q[$];
  event look;
  string nm[6] = '{"dir", "opMode", "uartLevel", "linkFlags", "syncRun",
    "modeFlags"};

  always #20 clk = ~clk;

  ups_if ifc();
  ups_device u_ups_device (.clk(clk), .porLowN(porLowN), .lnk(ifc),
    .coreSupply1v8(core), .usbSupply3v3(u33), .referenceClockIn(reference_clock_in),
    .pllLocked(lock), .uartRegulatorLevelSelIn(lvlIn),
    .uartLevelWrite(lvlWr), .devRunning(running), .regAccessOnly(regOnly),
    .standby(stby), .syncMode(sync), .uartRegulatorLevelSel(lvl),
    .opMode(mode));
  // Default pulse width keeps the pin low for a full microsecond
  ups_link u_ups_link (.clk(clk), .nrst(nrst),
    .lnk(ifc), .supplyStable(sup), .linkReady(rdy), .holdStp(hold),
    .resetReq(rreq), .busPresent(bus), .busInterrupt(bint),
    .phyReady(phyReady), .lowPowerReq(lowPower));
  ups_chk u_ups_chk (.clk(clk), .nrst(nrst), .pllLocked(lock),
    .hwResetLowPin(ifc.hwResetLowPin), .dir(ifc.dir), .stp(ifc.stp),
    .devData(ifc.devData), .devDataOe(ifc.devDataOe), .linkData(ifc.linkData),
    .linkDataOe(ifc.linkDataOe));

  // ****************************************************************
  // Checking
  // ****************************************************************
  function automatic logic [7:0] seen(int k);
    case (k)
      0: return {7'h00, ifc.dir};
      1: return {5'h00, mode};
      2: return {6'h00, lvl};
      3: return {6'h00, phyReady, lowPower};
      4: return {6'h00, sync, running};
      default: return {6'h00, regOnly, stby};
    endcase
  endfunction : seen

  // Draining in a loop so notes posted together are never lost
  always @(look) begin : watch
    ups_note_t n;
    logic [7:0] s;
    while (q.size() > 0) begin
      n = q.pop_front();
      s = seen(n.k);
      nChecks++;
      if (s !== n.e) begin
        errors++;
        $display("unexpected %s exp %h got %h", nm[n.k], n.e, s);
      end
    end
  end

  task automatic chk(int k, logic [7:0] e);
    #1;
    q.push_back('{k, e});
    ->look;
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic waitDir(logic e);
    for (int i = 0; i < 60 && ifc.dir !== e; i++) @(posedge clk);
    chk(0, {7'h00, e});
  endtask : waitDir

  task automatic summarize;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    cyc(1500);
    errors++;
    summarize();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    cyc(6);
    nrst <= 1'b1;
    porLowN <= 1'b1;
    cyc(40);
    chk(0, 8'h01);
    @(posedge clk) hold <= 1'b0;
    waitDir(1'b0);
    chk(3, 8'h02);
    chk(1, {5'h00, ups_pkg::UPS_MODE_FULL});
    chk(5, 8'h00);
    chk(4, 8'h03);
    $display("test start done");
    @(posedge clk) begin reference_clock_in <= 1'b0; lock <= 1'b0; rreq <= 1'b1; end
    @(posedge clk) rreq <= 1'b0;
    cyc(40);
    chk(0, 8'h01);
    @(posedge clk) reference_clock_in <= 1'b1;
    cyc(5);
    chk(0, 8'h01);
    @(posedge clk) lock <= 1'b1;
    waitDir(1'b0);
    $display("test lateClock done");
    repeat (6) begin
      v = $random(seed);
      @(posedge clk) begin lvlIn <= v[1:0]; lvlWr <= 1'b1; end
      @(posedge clk) lvlWr <= 1'b0;
      chk(2, {6'h00, v[1:0]});
    end
    @(posedge clk) begin lvlIn <= 2'h3; lvlWr <= 1'b1; end
    @(posedge clk) lvlWr <= 1'b0;
    chk(2, 8'h03);
    $display("test uart done");
    @(posedge clk) u33 <= 1'b0;
    chk(1, {5'h00, ups_pkg::UPS_MODE_REG_ONLY});
    chk(5, 8'h02);
    @(posedge clk) begin core <= 1'b0; u33 <= 1'b1; end
    chk(1, {5'h00, ups_pkg::UPS_MODE_INACTIVE});
    @(posedge clk) u33 <= 1'b0;
    chk(1, {5'h00, ups_pkg::UPS_MODE_OFF});
    @(posedge clk) begin core <= 1'b1; u33 <= 1'b0; rdy <= 1'b0; end
    chk(2, {6'h00, ups_pkg::UART_LEVEL_RST});
    @(posedge clk) rreq <= 1'b1;
    @(posedge clk) rreq <= 1'b0;
    cyc(3);
    chk(1, {5'h00, ups_pkg::UPS_MODE_STANDBY});
    chk(5, 8'h01);
    @(posedge clk) begin rdy <= 1'b1; u33 <= 1'b1; end
    waitDir(1'b0);
    $display("test modes done");
    @(posedge clk) porLowN <= 1'b0;
    chk(0, 8'h01);
    @(posedge clk) porLowN <= 1'b1;
    waitDir(1'b0);
    $display("test por done");
    @(posedge clk) bus <= 1'b0;
    cyc(3);
    chk(3, 8'h01);
    @(posedge clk) begin bus <= 1'b1; bint <= 1'b1; end
    @(posedge clk) bint <= 1'b0;
    cyc(10);
    chk(3, 8'h02);
    chk(0, 8'h00);
    $display("test busLoss done");
    summarize();
  end
endmodule : ulpi_phy_startup_reset_sequencer_bench
